// *** core/sld_device.sv ***
// driver device end: shift register, latches and gated outputs
// assumes link pins are asynchronous to clk_i
`include "sld_defines.svh"
`default_nettype none
module sld_device
   import sld_pkg::*;
#(
   parameter int WIDTH = `SLD_WIDTH,
   parameter int DELAY_CYC = `SLD_OUT_DELAY_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link pins
   sld_link_if.dev link,
   // parallel outputs
   output logic [WIDTH-1:0] out_o,
   output logic [WIDTH-1:0] latch_o
);
   // synchronised pin levels
   logic sdata_s;
   logic sclk_s;
   logic stb_s;
   logic oe_n_s;

   // shift clock edge detect
   logic sclk_d_ff;
   logic sclk_rise;

   // shift register and cascade stage
   logic [WIDTH-1:0] shift_ff;
   logic [WIDTH-1:0] nxt_shift;
   logic casc_ff;
   logic nxt_casc;

   // output latches
   logic [WIDTH-1:0] latch_ff;
   logic [WIDTH-1:0] nxt_latch;

   // latency line and gated output stage
   logic [WIDTH-1:0] dly_ff [DELAY_CYC];
   logic [WIDTH-1:0] dly_tail;
   logic [WIDTH-1:0] out_ff;
   logic [WIDTH-1:0] nxt_out;

   // pins come from another chip's flops, so each is resynchronised
   // serial data level
   sld_sync #(
      .RST_VAL(1'b0)
   ) u_sd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(link.sdata),
      .lvl_o(sdata_s)
   );

   // shift clock, idle low, so no false edge after reset
   sld_sync #(
      .RST_VAL(1'b0)
   ) u_sc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(link.sclk),
      .lvl_o(sclk_s)
   );

   // latch load level
   sld_sync #(
      .RST_VAL(1'b0)
   ) u_st (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(link.strobe),
      .lvl_o(stb_s)
   );

   // enable starts at its disabled level, as the host drives it
   sld_sync #(
      .RST_VAL(1'b1)
   ) u_oe (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(link.oe_n),
      .lvl_o(oe_n_s)
   );

   // rising edge of the synchronised shift clock
   assign sclk_rise = sclk_s & ~sclk_d_ff;

   // new bit enters stage 0, older bits move one stage on
   assign nxt_shift = sclk_rise ? {shift_ff[WIDTH-2:0], sdata_s} : shift_ff;

   // last stage feeds the next device in a chain
   assign nxt_casc = nxt_shift[WIDTH-1];

   // oldest entry of the latency line
   assign dly_tail = dly_ff[DELAY_CYC-1];

   // per bit: latch follows while strobe high, output gated by enable
   genvar bi;
   generate
      for (bi = 0; bi < WIDTH; bi++) begin : g_bit
         assign nxt_latch[bi] = stb_s ? shift_ff[bi] : latch_ff[bi];
         assign nxt_out[bi] = oe_n_s ? 1'b0 : dly_tail[bi];
      end
   endgenerate

   // edge detector
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_d_ff <= 1'b0;
      end else begin
         sclk_d_ff <= sclk_s;
      end
   end

   // shift register moves only on a shift clock edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_ff <= '0;
         casc_ff <= 1'b0;
      end else begin
         shift_ff <= nxt_shift;
         casc_ff <= nxt_casc;
      end
   end

   // enable is not an input here: latches never see it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_ff <= '0;
      end else begin
         latch_ff <= nxt_latch;
      end
   end

   // output stage reacts to enable without the latency
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_ff <= '0;
      end else begin
         out_ff <= nxt_out;
      end
   end

   // fixed latency from latch to output stage
   genvar gi;
   generate
      for (gi = 0; gi < DELAY_CYC; gi++) begin : g_dly
         if (gi == 0) begin : g_head
            // head of the line takes the latches
            always_ff @(posedge clk_i) begin
               if (rst_i) begin
                  dly_ff[gi] <= '0;
               end else begin
                  dly_ff[gi] <= latch_ff;
               end
            end
         end else begin : g_link
            // later entries pass the word one place on
            always_ff @(posedge clk_i) begin
               if (rst_i) begin
                  dly_ff[gi] <= '0;
               end else begin
                  dly_ff[gi] <= dly_ff[gi-1];
               end
            end
         end
      end
   endgenerate

   // every output comes straight from a flop
   assign link.cascade = casc_ff;
   assign out_o = out_ff;
   assign latch_o = latch_ff;
endmodule
`default_nettype wire

// *** core/sld_defines.svh ***
// timing constants for the serial latched driver link
// assumes a 40 MHz system clock on both ends
`ifndef SLD_DEFINES_SVH
`define SLD_DEFINES_SVH
`define SLD_CLK_PERIOD_NS 25
`define SLD_WIDTH 8
`define SLD_SETUP_NS 75
`define SLD_HOLD_NS 75
`define SLD_PULSE_NS 150
`define SLD_CLK_TO_STB_NS 300
`define SLD_STB_NS 100
`define SLD_OUT_DELAY_NS 1000
// least times round up, the latency rounds down
`define SLD_SETUP_CYC ((`SLD_SETUP_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)
`define SLD_HOLD_CYC ((`SLD_HOLD_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)
`define SLD_PULSE_CYC ((`SLD_PULSE_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)
`define SLD_CLK_TO_STB_CYC ((`SLD_CLK_TO_STB_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)
`define SLD_STB_CYC ((`SLD_STB_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)
`define SLD_OUT_DELAY_CYC (`SLD_OUT_DELAY_NS / `SLD_CLK_PERIOD_NS)
`endif

// *** core/sld_pkg.sv ***
// types shared by both ends of the serial latched driver link
// assumes nothing beyond the defines header
`default_nettype none
package sld_pkg;
   typedef enum logic [2:0] {
      SLD_IDLE = 3'b000,
      SLD_SETUP = 3'b001,
      SLD_HIGH = 3'b010,
      SLD_LOW = 3'b011,
      SLD_GAP = 3'b100,
      SLD_STB = 3'b101
   } sld_host_state_t;
endpackage
`default_nettype wire

// *** core/sld_link_if.sv ***
// pin bundle between host controller and driver device
// assumes both ends share clk_i
`default_nettype none
interface sld_link_if;
   logic sdata;
   logic sclk;
   logic strobe;
   logic oe_n;
   logic cascade;
   modport host (output sdata, output sclk, output strobe, output oe_n, input cascade);
   modport dev (input sdata, input sclk, input strobe, input oe_n, output cascade);
endinterface
`default_nettype wire

// *** core/sld_sync.sv ***
// three-stage synchroniser for one pin, with stable-level output
// assumes an asynchronous input and clk_i domain
`default_nettype none
module sld_sync #(
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pin and filtered level
   input wire logic pin_i,
   output logic lvl_o
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic lvl_ff;
   wire agree = (s2_ff == s3_ff);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
         lvl_ff <= RST_VAL;
      end else begin
         s1_ff <= pin_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (agree) begin
            lvl_ff <= s3_ff;
         end
      end
   end
   assign lvl_o = lvl_ff;
endmodule
`default_nettype wire

// *** core/sld_host.sv ***
// host controller end: shifts a byte out, then pulses strobe
// assumes the device samples the pins through synchronisers
`include "sld_defines.svh"
`default_nettype none
module sld_host
   import sld_pkg::*;
#(
   parameter int WIDTH = `SLD_WIDTH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // user request
   input wire logic start_i,
   input wire logic [WIDTH-1:0] data_i,
   input wire logic oe_n_i,
   output logic busy_o,
   output logic done_o,
   // link pins
   sld_link_if.host link
);
   localparam int SU = `SLD_SETUP_CYC;
   localparam int PW = `SLD_PULSE_CYC;
   localparam int GAP = `SLD_CLK_TO_STB_CYC;
   localparam int STB = `SLD_STB_CYC;
   sld_host_state_t st_ff;
   logic [7:0] cnt_ff;
   logic [WIDTH-1:0] sh_ff;
   logic [3:0] bit_ff;
   logic sd_ff;
   logic sc_ff;
   logic stb_ff;
   logic oe_n_ff;
   logic busy_ff;
   logic done_ff;
   // high half covers hold, 150 ns pulse meets both minima
   wire cnt_done = (cnt_ff == 8'h00);
   wire last_bit = (bit_ff == 4'(WIDTH - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= SLD_IDLE;
         cnt_ff <= 8'h00;
         sh_ff <= '0;
         bit_ff <= 4'h0;
         sd_ff <= 1'b0;
         sc_ff <= 1'b0;
         stb_ff <= 1'b0;
         oe_n_ff <= 1'b1;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         oe_n_ff <= oe_n_i;
         if (!cnt_done) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
         unique case (st_ff)
            SLD_IDLE: begin
               if (start_i) begin
                  sh_ff <= data_i;
                  bit_ff <= 4'h0;
                  busy_ff <= 1'b1;
                  sd_ff <= data_i[WIDTH-1];
                  cnt_ff <= 8'(PW - 1);
                  st_ff <= SLD_SETUP;
               end
            end
            SLD_SETUP: if (cnt_done) begin
               sc_ff <= 1'b1;
               cnt_ff <= 8'(PW - 1);
               st_ff <= SLD_HIGH;
            end
            SLD_HIGH: if (cnt_done) begin
               sc_ff <= 1'b0;
               cnt_ff <= 8'(PW - 1);
               st_ff <= SLD_LOW;
            end
            SLD_LOW: begin
               if (last_bit) begin
                  cnt_ff <= 8'(GAP - 1);
                  st_ff <= SLD_GAP;
               end else if (cnt_done) begin
                  sh_ff <= {sh_ff[WIDTH-2:0], 1'b0};
                  sd_ff <= sh_ff[WIDTH-2];
                  bit_ff <= bit_ff + 4'h1;
                  cnt_ff <= 8'(SU > PW ? SU : PW);
                  st_ff <= SLD_SETUP;
               end
            end
            SLD_GAP: if (cnt_done) begin
               stb_ff <= 1'b1;
               cnt_ff <= 8'(STB + 2);
               st_ff <= SLD_STB;
            end
            SLD_STB: if (cnt_done) begin
               stb_ff <= 1'b0;
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
               st_ff <= SLD_IDLE;
            end
            default: st_ff <= SLD_IDLE;
         endcase
      end
   end

   assign link.sdata = sd_ff;
   assign link.sclk = sc_ff;
   assign link.strobe = stb_ff;
   assign link.oe_n = oe_n_ff;
   assign busy_o = busy_ff;
   assign done_o = done_ff;
endmodule
`default_nettype wire

// *** verification/sld_assertions.sv ***
// checker on the link pins between host and device
// assumes instantiation beside the link in the bench
`default_nettype none
module sld_assertions (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link pins
   input wire logic sdata,
   input wire logic sclk,
   input wire logic strobe,
   input wire logic oe_n,
   input wire logic cascade
);
   logic sclk_q_ff;
   logic [4:0] since_ff;
   wire logic rise = sclk & ~sclk_q_ff;
   wire logic [4:0] nxt_since = rise ? 5'h00 : since_ff + {4'h0, since_ff != 5'h1f};
   always_ff @(posedge clk_i) begin
      sclk_q_ff <= sclk;
      since_ff <= rst_i ? 5'h00 : nxt_since;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_SETUP: assert property ($rose(sclk) |-> sdata == $past(sdata, 1) && sdata == $past(sdata, 3))
      else $error("data setup short");
   AST_HOLD: assert property ($rose(sclk) |=> $stable(sdata) [*3])
      else $error("data hold short");
   AST_CLK_HIGH: assert property ($rose(sclk) |-> sclk [*6])
      else $error("clock high short");
   AST_CLK_LOW: assert property ($fell(sclk) |-> !sclk [*6])
      else $error("clock low short");
   AST_DATA_WIDTH: assert property ($changed(sdata) |=> $stable(sdata) [*5])
      else $error("data pulse short");
   AST_CLK_TO_STB: assert property ($rose(strobe) |-> since_ff >= 5'h0b)
      else $error("strobe too soon");
   AST_STB_WIDTH: assert property ($rose(strobe) |-> strobe [*4])
      else $error("strobe short");
   AST_CASCADE: assert property ($changed(cascade) |-> sclk || $past(sclk, 1))
      else $error("cascade moved off clock");
   cover property ($rose(strobe));
   cover property ($changed(cascade));
   cover property ($fell(oe_n));
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench: host and device joined over the link
// assumes 40 MHz clock and a short output latency
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic start_i = 1'b0;
   logic [7:0] data_i = 8'h00;
   logic oe_n_i = 1'b1;
   logic done_o;
   logic busy_o;
   logic [7:0] out_o;
   logic [7:0] latch_o;
   logic [7:0] prev = 8'h00;
   logic [7:0] vals [5] = '{8'ha5, 8'h3c, 8'hff, 8'h00, 8'h81};
   int n_errors = 0;
   int tests_run = 0;
   sld_link_if link();
   sld_host i_sld_host (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .data_i(data_i), .oe_n_i(oe_n_i),
      .busy_o(busy_o), .done_o(done_o), .link(link));
   sld_device #(.DELAY_CYC(2)) i_sld_device (.clk_i(clk_i), .rst_i(rst_i), .link(link), .out_o(out_o),
      .latch_o(latch_o));
   sld_assertions i_sld_assertions (.clk_i(clk_i), .rst_i(rst_i), .sdata(link.sdata), .sclk(link.sclk),
      .strobe(link.strobe), .oe_n(link.oe_n), .cascade(link.cascade));
   always #12.5 clk_i = ~clk_i;
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic final_report();
      $display("errors=%0d tests=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask
   // one byte out, then flip the enable
   task automatic send(input logic [7:0] v, input logic oe);
      int i;
      step(1);
      start_i = 1'b1;
      data_i = v;
      oe_n_i = oe;
      step(1);
      start_i = 1'b0;
      step(50);
      chk(prev, latch_o);
      chk(8'h01, {7'h00, busy_o});
      for (i = 0; i < 400 && done_o !== 1'b1; i++) step(1);
      if (i == 400) n_errors++;
      step(20);
      chk(v, latch_o);
      chk(8'h00, {7'h00, busy_o});
      chk(oe ? 8'h00 : v, out_o);
      chk({7'h00, v[7]}, {7'h00, link.cascade});
      oe_n_i = ~oe;
      step(10);
      chk(oe ? v : 8'h00, out_o);
      chk(v, latch_o);
      prev = v;
   endtask
   initial begin
      step(5);
      rst_i = 1'b0;
      foreach (vals[k]) send(vals[k], k[0]);
      final_report();
   end
   initial begin
      repeat (4000) @(posedge clk_i);
      n_errors++;
      final_report();
   end
endmodule
`default_nettype wire
